// ===== acl_pkg.sv
// constants and types shared by the accumulator load unit and its stack
// assumes a single cpu clock domain; no software-visible registers
package acl_pkg;

    localparam int ACC_W = 32;
    localparam int WORD_W = 16;
    localparam int STACK_DEPTH = 8;
    localparam int CNT_W = 6;
    localparam int OCT_DIGITS = 6;
    localparam int OCT_W = 24;
    localparam logic [CNT_W-1:0] FMT_MAX_BITS = 6'h20;
    localparam logic [CNT_W-1:0] FMT_MIN_BITS = 6'h01;
    localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ACL_OP_NONE = 3'h0,
        ACL_OP_FMT = 3'h1,
        ACL_OP_OCT = 3'h2,
        ACL_OP_IDX = 3'h3,
        ACL_OP_TBL = 3'h4,
        ACL_OP_OUT = 3'h5
    } acl_op_t;

    typedef enum logic [1:0] {
        ACL_SP_BIT = 2'h0,
        ACL_SP_WORD = 2'h1,
        ACL_SP_TABLE = 2'h2
    } acl_space_t;

    typedef enum logic [1:0] {
        ACL_ST_IDLE = 2'b00,
        ACL_ST_WAIT = 2'b01
    } acl_state_t;

endpackage

// ===== acl_stack.sv
// eight-level accumulator stack, every level a register
// assumes push is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module acl_stack import acl_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic push,
    input wire logic [ACC_W-1:0] pushData,
    output logic [ACC_W-1:0] levelOne,
    output logic [STACK_DEPTH-1:0][ACC_W-1:0] levels
);

    typedef struct packed {
        logic [STACK_DEPTH-1:0][ACC_W-1:0] lvl;
    } acl_stack_state_t;

    acl_stack_state_t q;
    acl_stack_state_t d;

    always_comb begin
        d = q;
        if (push) begin
            // level 8 falls off the bottom and is lost
            d.lvl[0] = pushData;
            for (int i = 1; i < STACK_DEPTH; i++) begin
                d.lvl[i] = q.lvl[i-1];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign levelOne = q.lvl[0];
    assign levels = q.lvl;

endmodule

// ===== acl_load_unit.sv
// accumulator load unit: load-type instructions into a 32-bit accumulator
// the eight-level stack is a submodule that pushes only when told from here
// assumes the data and bit memories answer on the same clock with rdAck
`timescale 1ns/1ps
module acl_load_unit import acl_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire acl_op_t cmdOp,
    input wire logic [WORD_W-1:0] cmdAddr,
    input wire logic [CNT_W-1:0] cmdCount,
    input wire logic [OCT_W-1:0] cmdOctal,
    input wire logic scanEnd,
    output logic rdReq,
    output acl_space_t rdSpace,
    output logic [WORD_W-1:0] rdAddr,
    output logic [WORD_W-1:0] rdIndex,
    input wire logic rdAck,
    input wire logic [ACC_W-1:0] rdData,
    output logic [ACC_W-1:0] accumulator,
    output logic loadZeroFlag,
    output logic loadDone,
    output logic [STACK_DEPTH-1:0][ACC_W-1:0] stackLevels
);

    typedef struct packed {
        acl_state_t st;
        logic [ACC_W-1:0] acc;
        logic zero;
        logic pending;
        acl_op_t op;
        logic [CNT_W-1:0] count;
        logic req;
        acl_space_t space;
        logic [WORD_W-1:0] addr;
        logic [WORD_W-1:0] index;
        logic done;
    } acl_state_s_t;

    acl_state_s_t q;
    acl_state_s_t d;
    logic push;
    logic [ACC_W-1:0] levelOne;
    logic [ACC_W-1:0] newValue;
    logic newLoad;
    logic [WORD_W-1:0] offset;

    ////////////////////////////////////////////////////////////////////////

    // keeps the low count bits; out-of-range counts are clamped to 1..32
    function automatic logic [ACC_W-1:0] fmt_mask(input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] c;
        logic [ACC_W-1:0] m;
        c = cnt;
        m = '1;
        if (c > FMT_MAX_BITS) begin
            c = FMT_MAX_BITS;
        end
        if (c < FMT_MIN_BITS) begin
            c = FMT_MIN_BITS;
        end
        if (c != FMT_MAX_BITS) begin
            m = ~({ACC_W{1'b1}} << c);
        end
        return m;
    endfunction

    // each operand digit sits in a nibble; only its low three bits count
    // the top two bits of a sixth digit do not fit in sixteen bits and are dropped
    function automatic logic [WORD_W-1:0] oct_to_bin(input logic [OCT_W-1:0] o);
        logic [3*OCT_DIGITS-1:0] b;
        b = '0;
        for (int i = 0; i < OCT_DIGITS; i++) begin
            b[3*i +: 3] = o[4*i +: 3];
        end
        return b[WORD_W-1:0];
    endfunction

    // 16-bit loads leave the upper accumulator half at zero
    function automatic logic [ACC_W-1:0] word_fill(input logic [WORD_W-1:0] w);
        return {{(ACC_W-WORD_W){1'b0}}, w};
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // octal loads write the accumulator at the taking edge;
    // memory loads raise rdReq there and write one edge after rdAck
    always_comb begin
        d = q;
        push = 1'b0;
        newLoad = 1'b0;
        newValue = '0;
        d.done = 1'b0;
        // a push that goes with this load makes the old accumulator level one
        offset = q.pending ? q.acc[WORD_W-1:0] : levelOne[WORD_W-1:0];
        case (q.st)
            ACL_ST_IDLE: begin
                if (cmdValid) begin
                    case (cmdOp)
                        ACL_OP_FMT, ACL_OP_IDX, ACL_OP_TBL: begin
                            // only the pending push; the indexed read itself never pushes
                            push = q.pending;
                            d.pending = 1'b0;
                            d.op = cmdOp;
                            d.count = cmdCount;
                            d.addr = cmdAddr;
                            d.req = 1'b1;
                            d.st = ACL_ST_WAIT;
                            d.index = '0;
                            d.space = ACL_SP_BIT;
                            if (cmdOp == ACL_OP_IDX) begin
                                d.space = ACL_SP_WORD;
                                d.addr = cmdAddr + offset;
                            end else if (cmdOp == ACL_OP_TBL) begin
                                d.space = ACL_SP_TABLE;
                                d.index = offset;
                            end
                        end
                        ACL_OP_OCT: begin
                            push = q.pending;
                            newLoad = 1'b1;
                            newValue = word_fill(oct_to_bin(cmdOctal));
                        end
                        ACL_OP_OUT: begin
                            // the output consumes the load; the next load starts a new chain
                            d.pending = 1'b0;
                        end
                        default: begin
                            // no operation: the command is taken and dropped
                        end
                    endcase
                end
            end
            ACL_ST_WAIT: begin
                // the read stays requested until rdAck; commands wait meanwhile
                if (rdAck) begin
                    d.req = 1'b0;
                    d.st = ACL_ST_IDLE;
                    newLoad = 1'b1;
                    if (q.op == ACL_OP_FMT) begin
                        newValue = rdData & fmt_mask(q.count);
                    end else begin
                        newValue = word_fill(rdData[WORD_W-1:0]);
                    end
                end
            end
            default: begin
                // an unknown state drops the read and returns to idle
                d.st = ACL_ST_IDLE;
                d.req = 1'b0;
            end
        endcase
        // every finished load arms the push for the load after it, except one that scan end meets in the same cycle
        if (newLoad) begin
            d.acc = newValue;
            d.zero = (newValue == '0);
            d.pending = 1'b1;
            d.done = 1'b1;
        end
        // scan end wins over a load finishing in the same cycle
        if (scanEnd) begin
            d.acc = ACC_RESET;
            d.pending = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '{
                st: ACL_ST_IDLE,
                acc: ACC_RESET,
                op: ACL_OP_NONE,
                space: ACL_SP_BIT,
                default: '0
            };
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    // level one is the offset source of the indexed loads
    acl_stack u_stack (
        .clock(clock),
        .nrst(nrst),
        .push(push),
        .pushData(q.acc),
        .levelOne(levelOne),
        .levels(stackLevels)
    );

    // commands are refused while a memory read is outstanding
    assign cmdReady = (q.st == ACL_ST_IDLE);
    assign rdReq = q.req;
    assign rdSpace = q.space;
    assign rdAddr = q.addr;
    assign rdIndex = q.index;
    assign accumulator = q.acc;
    assign loadZeroFlag = q.zero;
    assign loadDone = q.done;

endmodule

// ===== acl_load_unit_sva.sv
// assertions on the load unit ports
// assumes one clock domain; bound at the foot
`timescale 1ns/1ps
module acl_load_unit_sva import acl_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic scanEnd,
    input wire logic rdReq,
    input wire logic rdAck,
    input wire logic loadZeroFlag,
    input wire logic loadDone,
    input wire acl_op_t cmdOp,
    input wire logic [CNT_W-1:0] cmdCount,
    input wire acl_space_t rdSpace,
    input wire logic [WORD_W-1:0] cmdAddr,
    input wire logic [WORD_W-1:0] rdAddr,
    input wire logic [WORD_W-1:0] rdIndex,
    input wire logic [ACC_W-1:0] rdData,
    input wire logic [ACC_W-1:0] accumulator,
    input wire logic [STACK_DEPTH-1:0][ACC_W-1:0] stackLevels
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire go = cmdValid && cmdReady && !scanEnd;
    wire ak = rdReq && rdAck && !scanEnd;
    logic [ACC_W-1:0] fmtMaskQ;
    // bits a formatted load may keep; count 0 reads as 1, above 32 as 32
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fmtMaskQ <= '0;
        end else if (go && cmdOp == ACL_OP_FMT) begin
            if (cmdCount == 6'h00) begin
                fmtMaskQ <= 32'h0000_0001;
            end else if (cmdCount >= 6'h20) begin
                fmtMaskQ <= 32'hFFFF_FFFF;
            end else begin
                fmtMaskQ <= 32'hFFFF_FFFF >> (6'h20 - cmdCount);
            end
        end
    end
    chk_oct_load: assert property (go && cmdOp == ACL_OP_OCT
        |=> loadDone && accumulator[31:16] == 16'h0000) else $error("octal load");
    chk_zero_flag: assert property (loadDone && !$past(scanEnd)
        |-> loadZeroFlag == (accumulator == ACC_RESET)) else $error("zero flag");
    chk_idx_addr: assert property (go && cmdOp == ACL_OP_IDX
        |=> rdAddr == $past(cmdAddr) + stackLevels[0][15:0]) else $error("index address");
    chk_tbl_index: assert property (go && cmdOp == ACL_OP_TBL
        |=> rdSpace == ACL_SP_TABLE && rdIndex == stackLevels[0][15:0]) else $error("table index");
    chk_word_fill: assert property (ak && rdSpace != ACL_SP_BIT
        |=> accumulator == {16'h0000, $past(rdData[15:0])}) else $error("word fill");
    chk_fmt_clear: assert property (ak && rdSpace == ACL_SP_BIT
        |=> loadDone && accumulator == ($past(rdData) & fmtMaskQ)) else $error("bit load");
    chk_scan_clear: assert property (scanEnd |=> accumulator == ACC_RESET)
        else $error("scan clear");
    chk_out_cancel: assert property (go && cmdOp == ACL_OP_OUT ##1 go
        |=> $stable(stackLevels)) else $error("out push");
    cover property (go && cmdOp == ACL_OP_TBL);
    cover property (ak && rdSpace == ACL_SP_BIT);
    cover property (loadDone && stackLevels[7] != ACC_RESET);
    cover property (go && cmdOp == ACL_OP_OUT ##1 go);
endmodule
////////////////////////////////
bind acl_load_unit acl_load_unit_sva chk (.*);

// ===== acl_mem_model.sv
// memory partner: bit, word and constant table spaces
// assumes reads stay requested until acknowledged
`timescale 1ns/1ps
module acl_mem_model import acl_pkg::*; (
    input wire logic clock,
    input wire logic nrst,
    input wire logic rdReq,
    input wire acl_space_t rdSpace,
    input wire logic [WORD_W-1:0] rdAddr,
    input wire logic [WORD_W-1:0] rdIndex,
    input wire logic [1:0] lag,
    output logic rdAck,
    output logic [ACC_W-1:0] rdData
);
    logic [1:0] wt;
    logic [ACC_W-1:0] b;
    wire [15:0] lo = rdSpace == ACL_SP_WORD ? rdAddr ^ 16'h5A3C : rdAddr ^ {rdIndex[7:0], rdIndex[15:8]};
    always_comb for (int n = 0; n < 32; n++) b[n] = ^(16'(rdAddr + n) & 16'h0095);
    // junk upper half and toggling idle data, so stale values never pass
    always @(posedge clock or negedge nrst) begin
        if (!nrst) {wt, rdAck, rdData} <= '0;
        else if (rdReq && !rdAck && wt == lag) begin
            rdAck <= 1'b1;
            wt <= 2'h0;
            rdData <= rdSpace == ACL_SP_BIT ? b : {~rdAddr, lo};
        end else begin
            rdAck <= 1'b0;
            wt <= rdReq && !rdAck ? wt + 2'h1 : 2'h0;
            rdData <= ~rdData;
        end
    end
endmodule

// ===== tb.sv
// bench: load unit against the memory partner
// assumes a 40 ns clock; inputs move on falling edges
`timescale 1ns/1ps
module tb;
    import acl_pkg::*;
    logic clock = 0, nrst = 0, cmdValid = 0, scanEnd = 0, pend = 0, cmdReady, rdReq, rdAck, loadZeroFlag, loadDone;
    logic [1:0] lag = 0;
    acl_op_t cmdOp = ACL_OP_NONE;
    acl_space_t rdSpace;
    logic [WORD_W-1:0] cmdAddr = 0, rdAddr, rdIndex;
    logic [CNT_W-1:0] cmdCount = 0;
    logic [OCT_W-1:0] cmdOctal = 0;
    logic [ACC_W-1:0] rdData, accumulator, acc = 0;
    logic [STACK_DEPTH-1:0][ACC_W-1:0] stackLevels, stk = 0;
    logic [287:0] notes[$];
    int err_total = 0, num_checks = 0;
    acl_load_unit uut (.*);
    acl_mem_model mem (.*);
    always #20 clock = ~clock;
    task automatic check(string what, logic [287:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // valid stays up between calls so loads can run back to back
    task automatic ld(acl_op_t op, logic [15:0] a, logic [23:0] o = 0, logic [5:0] c = 0);
        logic [31:0] v = 0;
        logic [15:0] off = pend ? acc[15:0] : stk[0][15:0];
        @(negedge clock);
        cmdValid = 1'b1;
        cmdOp = op;
        cmdAddr = a;
        cmdOctal = o;
        cmdCount = c;
        lag = 2'($urandom);
        for (int k = 0; k < 32; k++) begin
            if (op == ACL_OP_OCT && k < 6) v[3*k +: 3] = o[4*k +: 3];
            if (op == ACL_OP_FMT && (k < c || k == 0)) v[k] = ^(16'(a + k) & 16'h0095);
        end
        if (op == ACL_OP_IDX) v = 16'(a + off) ^ 16'h5A3C;
        if (op == ACL_OP_TBL) v = a ^ {off[7:0], off[15:8]};
        if (op != ACL_OP_FMT) v[31:16] = 16'h0000;
        if (op == ACL_OP_OUT) pend = 0;
        else begin
            if (pend) stk = {stk[6:0], acc};
            {acc, pend} = {v, 1'b1};
            notes.push_back({stk, acc});
        end
        while (!cmdReady) @(negedge clock);
        @(posedge clock);
    endtask
    task automatic scan();
        @(negedge clock);
        cmdValid = 0;
        while (!cmdReady) @(negedge clock);
        scanEnd = 1;
        @(negedge clock);
        scanEnd = 0;
        check("clear", accumulator, 0);
        {acc, pend} = 0;
    endtask
    always @(negedge clock) if (loadDone === 1'b1) begin
        check("load", {stackLevels, accumulator}, notes[0]);
        check("zero", loadZeroFlag, notes.pop_front() % 33'h100000000 == 0);
    end
    ////////////////////////////////
    initial begin
        logic [23:0] oc[4] = '{24'h0, 24'h177777, 24'h040400, 24'h25};
        logic [5:0] ct[6] = '{6'h01, 6'h20, 6'h07, 6'h13, 6'h00, 6'h3F};
        void'($urandom(51539));
        repeat (4) @(posedge clock);
        @(negedge clock) nrst = 1;
        foreach (oc[i]) ld(ACL_OP_OCT, 0, oc[i]);
        repeat (8) ld(ACL_OP_OCT, 0, 24'($urandom) & 24'h777777);
        ld(ACL_OP_OUT, 0);
        ld(ACL_OP_OCT, 0, 24'h7);
        scan();
        $display("octal test done");
        foreach (ct[i]) ld(ACL_OP_FMT, 16'($urandom), 0, ct[i]);
        scan();
        $display("bit test done");
        ld(ACL_OP_OCT, 0, 24'h25);
        ld(ACL_OP_IDX, 16'h0308);
        repeat (3) begin
            ld(ACL_OP_IDX, 16'($urandom));
            ld(ACL_OP_TBL, 16'($urandom_range(1, 16'hFFFF)));
            ld(ACL_OP_OUT, 0);
            ld(ACL_OP_TBL, 16'h0002);
        end
        scan();
        ld(ACL_OP_IDX, 16'h0100);
        scan();
        $display("indexed test done");
        wrap_up();
    end
    initial begin
        #400000;
        err_total++;
        wrap_up();
    end
endmodule
